// *** verilog/pcrs_scaler.sv ***
// Operation
// - count factor up to 5.9999; each counted edge adds or subtracts factor times multiplier
// - count multiplier selects 0.1, 0.01 or unity; unity is the default
// - default mode gives exactly one counting event per input pulse
// - quadrature four edge mode counts four edges per sensor pulse
// - two and four edge modes count rising and falling edges
// - rate channel uses only falling edges of the primary input
// - rate has its own factor and multiplier converting pulses to units
// - rate conversion multiplies by 1, 60 or 3600 per second, minute, hour
// - minimum rate update time programmable from 0.1 to 99.9 seconds
// - update time sets averaging interval only, scaling result unchanged
// - rate multiplier is unity by default, scaling by factor alone
// - rate accepts same factor and multiplier values as the count channel
// - count direction single edge mode counts one edge per pulse
`timescale 1ns/1ps
`include "pcrs_defs.svh"
module pcrs_scaler #(
	parameter int TENTH_CYCLES = `PCRS_TENTH_NS / `PCRS_CLK_NS
) (
	input  wire logic                    clk_i,
	input  wire logic                    rst_b_i,
	input  wire logic                    pin_a_i,
	input  wire logic                    pin_b_i,
	input  wire pcrs_pkg::pcrs_count_cfg_t count_cfg_i,
	input  wire pcrs_pkg::pcrs_rate_cfg_t  rate_cfg_i,
	output logic [31:0]                  count_o,
	output logic                         count_event_o,
	output logic [31:0]                  rate_o,
	output logic                         rate_valid_o,
	output logic                         rate_ovf_o
);
	import pcrs_pkg::*;

	logic [1:0]  a_sync_r;
	logic [1:0]  b_sync_r;
	logic        a_prev_r;
	logic        b_prev_r;
	logic [31:0] cnt_int_r;
	logic [19:0] cnt_frac_r;
	logic [31:0] count_r;
	logic        cnt_ev_r;
	logic [22:0] tick_cnt_r;
	logic [9:0]  tenth_cnt_r;
	logic [19:0] win_pulses_r;
	logic [31:0] rate_r;
	logic        rate_valid_r;
	logic        rate_ovf_r;
	logic [63:0] div_num_r;
	logic [31:0] div_den_r;
	logic        div_go_r;

	// only the second stage of each synchroniser is read
	wire a_now  = a_sync_r[1];
	wire b_now  = b_sync_r[1];
	wire a_rise = a_now & ~a_prev_r;
	wire a_fall = ~a_now & a_prev_r;
	wire b_rise = b_now & ~b_prev_r;
	wire b_fall = ~b_now & b_prev_r;
	wire a_edge = a_rise | a_fall;
	wire b_edge = b_rise | b_fall;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			a_sync_r <= 2'h0;
			b_sync_r <= 2'h0;
			a_prev_r <= 1'b0;
			b_prev_r <= 1'b0;
		end else begin
			a_sync_r <= {a_sync_r[0], pin_a_i};
			b_sync_r <= {b_sync_r[0], pin_b_i};
			a_prev_r <= a_now;
			b_prev_r <= b_now;
		end
	end

	// edge selection per mode; b high means count down in direction modes
	logic cnt_hit;
	logic cnt_up;
	always_comb begin
		cnt_hit = 1'b0;
		cnt_up  = 1'b1;
		case (count_cfg_i.edges_per_pulse)
			PCRS_SINGLE_EDGE_MODE: cnt_hit = a_rise;
			PCRS_COUNT_DIRECTION_SINGLE_EDGE_MODE: begin
				cnt_hit = a_rise;
				cnt_up  = ~b_now;
			end
			PCRS_COUNT_DIRECTION_TWO_EDGE_MODE: begin
				cnt_hit = a_edge;
				cnt_up  = ~b_now;
			end
			PCRS_QUADRATURE_ONE_EDGE_MODE: begin
				cnt_hit = a_rise;
				cnt_up  = ~b_now;
			end
			PCRS_QUADRATURE_TWO_EDGE_MODE: begin
				cnt_hit = a_edge;
				cnt_up  = a_now ^ b_now;
			end
			PCRS_QUADRATURE_FOUR_EDGE_MODE: begin
				cnt_hit = a_edge | b_edge;
				cnt_up  = a_edge ? (a_now ^ b_now) : (a_now ~^ b_now);
			end
			default: cnt_hit = 1'b0;
		endcase
	end

	wire [16:0] cnt_sf = (count_cfg_i.scale_factor > `PCRS_SF_MAX) ? `PCRS_SF_MAX : count_cfg_i.scale_factor;
	wire [6:0]  cnt_step = (count_cfg_i.scale_multiplier == PCRS_MULT_X0P1)  ? `PCRS_STEP_X0P1 :
	                       (count_cfg_i.scale_multiplier == PCRS_MULT_X0P01) ? `PCRS_STEP_X0P01 : `PCRS_STEP_X1;
	wire [23:0] cnt_inc  = 24'(cnt_sf * cnt_step);

	// fraction kept in millionths so sub-unit increments are never lost
	logic signed [24:0] frac_s;
	logic        [31:0] carry;
	always_comb begin
		frac_s = cnt_up ? $signed({5'h00, cnt_frac_r}) + $signed({1'b0, cnt_inc})
		                : $signed({5'h00, cnt_frac_r}) - $signed({1'b0, cnt_inc});
		carry  = '0;
		for (int i = 0; i < `PCRS_CARRY_STEPS; i++) begin
			if (frac_s >= `PCRS_MICRO) begin
				frac_s = frac_s - `PCRS_MICRO;
				carry  = carry + 32'h1;
			end else if (frac_s < 0) begin
				frac_s = frac_s + `PCRS_MICRO;
				carry  = carry - 32'h1;
			end
		end
	end
	wire [31:0] int_nxt  = cnt_int_r + carry;
	wire [19:0] frac_nxt = 20'(frac_s);
	wire [31:0] round_nxt = int_nxt + {31'h0, frac_nxt >= `PCRS_HALF};

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_int_r  <= `PCRS_CNT_RESET;
			cnt_frac_r <= '0;
			count_r    <= `PCRS_CNT_RESET;
			cnt_ev_r   <= 1'b0;
		end else begin
			cnt_ev_r <= cnt_hit;
			if (cnt_hit) begin
				cnt_int_r  <= int_nxt;
				cnt_frac_r <= frac_nxt;
				count_r    <= round_nxt;
			end
		end
	end

	wire [9:0] upd_eff = (rate_cfg_i.update_tenths < `PCRS_UPD_MIN) ? `PCRS_UPD_MIN :
	                     (rate_cfg_i.update_tenths > `PCRS_UPD_MAX) ? `PCRS_UPD_MAX : rate_cfg_i.update_tenths;
	wire tick    = tick_cnt_r == 23'(TENTH_CYCLES - 1);
	wire win_end = tick && (tenth_cnt_r >= upd_eff - 10'h001);

	wire rate_ev = a_fall;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tick_cnt_r   <= '0;
			tenth_cnt_r  <= '0;
			win_pulses_r <= '0;
		end else begin
			tick_cnt_r <= tick ? 23'h0 : tick_cnt_r + 23'h1;
			if (win_end) begin
				tenth_cnt_r  <= '0;
				win_pulses_r <= '0;
			end else begin
				tenth_cnt_r <= tick ? tenth_cnt_r + 10'h001 : tenth_cnt_r;
				if (rate_ev && win_pulses_r != `PCRS_PULSE_MAX)
					win_pulses_r <= win_pulses_r + 20'h00001;
			end
		end
	end

	wire [16:0] rt_sf = (rate_cfg_i.scale_factor > `PCRS_SF_MAX) ? `PCRS_SF_MAX : rate_cfg_i.scale_factor;
	wire [6:0]  rt_step = (rate_cfg_i.scale_multiplier == PCRS_MULT_X0P1)  ? `PCRS_STEP_X0P1 :
	                      (rate_cfg_i.scale_multiplier == PCRS_MULT_X0P01) ? `PCRS_STEP_X0P01 : `PCRS_STEP_X1;
	wire [11:0] rt_conv = (rate_cfg_i.rate_time_conversion == PCRS_RATE_PER_MINUTE) ? `PCRS_CONV_MIN :
	                      (rate_cfg_i.rate_time_conversion == PCRS_RATE_PER_HOUR)   ? `PCRS_CONV_HOUR : `PCRS_CONV_SEC;
	wire [35:0] rt_gain = 36'(rt_sf * rt_step * rt_conv);
	wire [59:0] rt_num  = 60'(win_pulses_r * rt_gain * `PCRS_TENTHS_SEC);
	wire [31:0] rt_den  = 32'(upd_eff * `PCRS_DEN_SCALE);

	logic        div_busy;
	logic        div_done;
	logic [63:0] div_quo;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_num_r <= '0;
			div_den_r <= '0;
			div_go_r  <= 1'b0;
		end else begin
			div_go_r <= win_end;
			if (win_end) begin
				div_num_r <= {4'h0, rt_num} + {33'h0, rt_den[31:1]};
				div_den_r <= rt_den;
			end
		end
	end

	// divide runs 64 clocks, far inside the shortest window
	pcrs_divider #(
		.NW (64),
		.DW (32)
	) u_div (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.start_i (div_go_r),
		.num_i   (div_num_r),
		.den_i   (div_den_r),
		.busy_o  (div_busy),
		.done_o  (div_done),
		.quo_o   (div_quo)
	);

	wire quo_big = |div_quo[63:32];
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rate_r       <= '0;
			rate_valid_r <= 1'b0;
			rate_ovf_r   <= 1'b0;
		end else begin
			rate_valid_r <= div_done;
			if (div_done) begin
				rate_r     <= quo_big ? `PCRS_RATE_MAX : div_quo[31:0];
				rate_ovf_r <= quo_big;
			end
		end
	end

	assign count_o       = count_r;
	assign count_event_o = cnt_ev_r;
	assign rate_o        = rate_r;
	assign rate_valid_o  = rate_valid_r;
	assign rate_ovf_o    = rate_ovf_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_window_closed;
		win_end ##1 div_go_r;
	endsequence
	sequence s_rate_out;
		##[64:70] rate_valid_o;
	endsequence

	a_single_one_step: assert property (
		cnt_hit && count_cfg_i.edges_per_pulse == PCRS_SINGLE_EDGE_MODE && cnt_inc == 24'hF4240
		|=> cnt_int_r == $past(cnt_int_r) + 32'h1 && cnt_frac_r == $past(cnt_frac_r))
		else $error("single edge pulse did not add one");
	a_quad_all_edges: assert property (
		count_cfg_i.edges_per_pulse == PCRS_QUADRATURE_FOUR_EDGE_MODE && (a_edge || b_edge) |=> count_event_o)
		else $error("four edge mode missed an edge");
	a_two_edge_fall: assert property (
		count_cfg_i.edges_per_pulse == PCRS_COUNT_DIRECTION_TWO_EDGE_MODE && a_fall |=> count_event_o)
		else $error("two edge mode missed a falling edge");
	a_dir_one_edge: assert property (
		count_cfg_i.edges_per_pulse == PCRS_COUNT_DIRECTION_SINGLE_EDGE_MODE && a_fall |=> !count_event_o)
		else $error("single edge mode counted a falling edge");
	a_rate_fall_only: assert property (
		!a_fall && !win_end |=> win_pulses_r == $past(win_pulses_r))
		else $error("rate pulses moved without a falling edge");
	a_factor_cap: assert property (
		cnt_hit |-> cnt_inc <= 24'(`PCRS_SF_MAX * `PCRS_STEP_X1) && frac_nxt < 20'(`PCRS_MICRO))
		else $error("count increment or fraction out of range");
	a_conv_factor: assert property (
		rate_cfg_i.rate_time_conversion == PCRS_RATE_PER_HOUR |-> rt_conv == 12'hE10)
		else $error("hour conversion not 3600");
	a_unity_mult: assert property (
		rate_cfg_i.scale_multiplier == PCRS_MULT_X1 && rate_cfg_i.rate_time_conversion == PCRS_RATE_PER_SECOND
		|-> rt_gain == 36'(rt_sf * `PCRS_STEP_X1))
		else $error("unity rate multiplier changed the gain");
	a_window_len: assert property (
		win_end |-> tick && tenth_cnt_r == upd_eff - 10'h001 && upd_eff >= 10'h001 && upd_eff <= 10'h3E7)
		else $error("update window length wrong");
	a_rate_result: assert property (
		s_window_closed |-> s_rate_out)
		else $error("rate result not produced after window");
	a_div_idle: assert property (
		win_end |-> !div_busy)
		else $error("window closed while divide still running");
endmodule // pcrs_scaler

// *** verilog/pcrs_defs.svh ***
`ifndef PCRS_DEFS_SVH
`define PCRS_DEFS_SVH
`define PCRS_CLK_NS       20
`define PCRS_TENTH_NS     100000000
`define PCRS_SF_MAX       17'h0EA5F
`define PCRS_MICRO        25'sh00F4240
`define PCRS_HALF         20'h7A120
`define PCRS_STEP_X1      7'h64
`define PCRS_STEP_X0P1    7'h0A
`define PCRS_STEP_X0P01   7'h01
`define PCRS_CONV_SEC     12'h001
`define PCRS_CONV_MIN     12'h03C
`define PCRS_CONV_HOUR    12'hE10
`define PCRS_UPD_MIN      10'h001
`define PCRS_UPD_MAX      10'h3E7
`define PCRS_TENTHS_SEC   4'hA
`define PCRS_DEN_SCALE    20'hF4240
`define PCRS_PULSE_MAX    20'hFFFFF
`define PCRS_CNT_RESET    32'h00000000
`define PCRS_RATE_MAX     32'hFFFFFFFF
`define PCRS_CARRY_STEPS  7
`endif

// *** verilog/pcrs_pkg.sv ***
package pcrs_pkg;
	typedef enum logic [2:0] {
		PCRS_SINGLE_EDGE_MODE,
		PCRS_COUNT_DIRECTION_SINGLE_EDGE_MODE,
		PCRS_COUNT_DIRECTION_TWO_EDGE_MODE,
		PCRS_QUADRATURE_ONE_EDGE_MODE,
		PCRS_QUADRATURE_TWO_EDGE_MODE,
		PCRS_QUADRATURE_FOUR_EDGE_MODE
	} pcrs_edges_per_pulse_t;
	typedef enum logic [1:0] {
		PCRS_MULT_X1,
		PCRS_MULT_X0P1,
		PCRS_MULT_X0P01
	} pcrs_scale_multiplier_t;
	typedef enum logic [1:0] {
		PCRS_RATE_PER_SECOND,
		PCRS_RATE_PER_MINUTE,
		PCRS_RATE_PER_HOUR
	} pcrs_rate_time_conversion_t;
	typedef struct packed {
		pcrs_edges_per_pulse_t  edges_per_pulse;
		logic [16:0]            scale_factor;
		pcrs_scale_multiplier_t scale_multiplier;
	} pcrs_count_cfg_t;
	typedef struct packed {
		logic [16:0]                scale_factor;
		pcrs_scale_multiplier_t     scale_multiplier;
		pcrs_rate_time_conversion_t rate_time_conversion;
		logic [9:0]                 update_tenths;
	} pcrs_rate_cfg_t;
endpackage

// *** verilog/pcrs_divider.sv ***
`timescale 1ns/1ps
module pcrs_divider #(
	parameter int NW = 64,
	parameter int DW = 32
) (
	input  wire logic          clk_i,
	input  wire logic          rst_b_i,
	input  wire logic          start_i,
	input  wire logic [NW-1:0] num_i,
	input  wire logic [DW-1:0] den_i,
	output logic               busy_o,
	output logic               done_o,
	output logic [NW-1:0]      quo_o
);
	logic [NW-1:0] quo_r;
	logic [DW:0]   rem_r;
	logic [DW-1:0] den_r;
	logic [6:0]    cnt_r;
	logic          busy_r;
	logic          done_r;
	wire  [DW:0]   rem_sh = {rem_r[DW-1:0], quo_r[NW-1]};
	wire           fits   = rem_sh >= {1'b0, den_r};

	// restoring divide, one quotient bit per clock
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			quo_r  <= '0;
			rem_r  <= '0;
			den_r  <= '0;
			cnt_r  <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (start_i && !busy_r) begin
				quo_r  <= num_i;
				rem_r  <= '0;
				den_r  <= den_i;
				cnt_r  <= 7'(NW);
				busy_r <= 1'b1;
			end else if (busy_r) begin
				rem_r  <= fits ? rem_sh - {1'b0, den_r} : rem_sh;
				quo_r  <= {quo_r[NW-2:0], fits};
				cnt_r  <= cnt_r - 7'h01;
				busy_r <= cnt_r != 7'h01;
				done_r <= cnt_r == 7'h01;
			end
		end
	end
	assign busy_o = busy_r;
	assign done_o = done_r;
	assign quo_o  = quo_r;
endmodule // pcrs_divider

// *** testbench/pcrs_sensor.sv ***
`timescale 1ns/1ps
module pcrs_sensor (
	input  wire logic clk_i,
	output logic      pin_a_o,
	output logic      pin_b_o
);
	initial begin
		pin_a_o = 1'b0;
		pin_b_o = 1'b0;
	end
	// quadrature phase order
	// each level held three clocks, above the two-clock minimum of the sync stage
	task automatic run(input int cycles, input bit rev);
		logic [7:0] ph;
		ph = rev ? 8'h78 : 8'hB4;
		for (int c = 0; c < cycles; c++) begin
			for (int p = 0; p < 4; p++) begin
				@(negedge clk_i);
				{pin_a_o, pin_b_o} = ph[7-2*p -: 2];
				repeat (2) @(negedge clk_i);
			end
		end
	endtask
endmodule // pcrs_sensor

// *** testbench/pcrs_scaler_bench.sv ***
`timescale 1ns/1ps
module pcrs_scaler_bench;
	import pcrs_pkg::*;
	localparam int TENTH = 120;
	logic            clk_i;
	logic            rst_b_i;
	logic            pin_a;
	logic            pin_b;
	pcrs_count_cfg_t ccfg;
	pcrs_rate_cfg_t  rcfg;
	logic [31:0]     count_o;
	logic [31:0]     rate_o;
	logic            count_event_o;
	logic            rate_valid_o;
	logic            rate_ovf_o;
	int              n_mismatch = 0;
	int              checked = 0;
	int              n_ev = 0;
	longint          acc = 0;

	pcrs_scaler #(.TENTH_CYCLES(TENTH)) u_pcrs_scaler (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .pin_a_i(pin_a), .pin_b_i(pin_b),
		.count_cfg_i(ccfg), .rate_cfg_i(rcfg), .count_o(count_o), .count_event_o(count_event_o),
		.rate_o(rate_o), .rate_valid_o(rate_valid_o), .rate_ovf_o(rate_ovf_o)
	);
	pcrs_sensor u_pcrs_sensor (.clk_i(clk_i), .pin_a_o(pin_a), .pin_b_o(pin_b));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (count_event_o === 1'b1) n_ev <= n_ev + 1;
	end

	function automatic longint stp(input pcrs_scale_multiplier_t m);
		return (m == PCRS_MULT_X1) ? 100 : (m == PCRS_MULT_X0P1) ? 10 : 1;
	endfunction
	function automatic longint cv(input pcrs_rate_time_conversion_t c);
		return (c == PCRS_RATE_PER_SECOND) ? 1 : (c == PCRS_RATE_PER_MINUTE) ? 60 : 3600;
	endfunction
	// net counts per sensor pulse in mode order; plain mode only ever counts up
	function automatic int net(input int m, input bit rev);
		int n;
		n = (m == 2) ? 0 : (m == 4) ? 2 : (m == 5) ? 4 : 1;
		return (rev && m != 0) ? -n : n;
	endfunction
	function automatic int evs(input int m);
		return (m == 2 || m == 4) ? 2 : (m == 5) ? 4 : 1;
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// expected count from a bench-side millionths accumulator, rounded half up
	task automatic count_chk(input int cyc, input bit rev, input int ev0);
		int m;
		m = int'(ccfg.edges_per_pulse);
		repeat (6) @(negedge clk_i);
		acc += longint'(cyc * net(m, rev)) * longint'(ccfg.scale_factor) * stp(ccfg.scale_multiplier);
		check(count_o, 32'((acc + 500000) / 1000000));
		check(32'(n_ev - ev0), 32'(cyc * evs(m)));
	endtask

	task automatic burst(input pcrs_edges_per_pulse_t e, input bit rev, input int cyc);
		int ev0;
		@(negedge clk_i);
		ccfg.edges_per_pulse = e;
		ev0 = n_ev;
		u_pcrs_sensor.run(cyc, rev);
		count_chk(cyc, rev, ev0);
	endtask

	// every mode, both directions, unit factor
	task automatic t_modes();
		ccfg.scale_factor = 17'h02710;
		ccfg.scale_multiplier = PCRS_MULT_X1;
		for (int r = 0; r < 2; r++) begin
			for (int m = 0; m < 6; m++) begin
				burst(pcrs_edges_per_pulse_t'(m), r[0], 3);
			end
		end
	endtask

	// factor limit, each multiplier, fractional carry
	task automatic mult_case(input logic [16:0] sf, input pcrs_scale_multiplier_t sm);
		@(negedge clk_i);
		ccfg.scale_factor = sf;
		ccfg.scale_multiplier = sm;
		burst(PCRS_SINGLE_EDGE_MODE, 1'b0, 3);
	endtask
	task automatic t_mult();
		mult_case(17'h0EA5F, PCRS_MULT_X1);
		mult_case(17'h01388, PCRS_MULT_X0P1);
		mult_case(17'h07530, PCRS_MULT_X0P01);
		mult_case(17'h01388, PCRS_MULT_X1);
	endtask

	// ten falling edges per tenth of a second; early windows are skipped
	task automatic rate_case(input logic [16:0] sf, input pcrs_scale_multiplier_t m,
			input pcrs_rate_time_conversion_t c, input logic [9:0] u, input pcrs_edges_per_pulse_t e);
		longint eff;
		longint exp;
		int     seen;
		int     ev0;
		@(negedge clk_i);
		rcfg = '{sf, m, c, u};
		ccfg.edges_per_pulse = e;
		ccfg.scale_factor = 17'h02710;
		ccfg.scale_multiplier = PCRS_MULT_X1;
		eff = (u == 10'h000) ? 1 : longint'(u);
		exp = (10 * eff * longint'(sf) * stp(m) * cv(c) * 10 + eff * 500000) / (eff * 1000000);
		seen = 0;
		ev0 = n_ev;
		fork
			u_pcrs_sensor.run(100, 1'b0);
			for (int i = 0; i < 1500 && seen < 4; i++) begin
				@(negedge clk_i);
				if (rate_valid_o === 1'b1) begin
					seen++;
					if (seen == 4) begin
						check(rate_o, 32'(exp));
						check({31'h0, rate_ovf_o}, 32'h0);
					end
				end
			end
		join
		check(32'(seen), 32'h4);
		count_chk(100, 1'b0, ev0);
	endtask

	task automatic t_rate();
		rate_case(17'h02710, PCRS_MULT_X1, PCRS_RATE_PER_SECOND, 10'h001, PCRS_SINGLE_EDGE_MODE);
		rate_case(17'h02710, PCRS_MULT_X1, PCRS_RATE_PER_MINUTE, 10'h001, PCRS_SINGLE_EDGE_MODE);
		rate_case(17'h02710, PCRS_MULT_X1, PCRS_RATE_PER_HOUR, 10'h001, PCRS_SINGLE_EDGE_MODE);
		rate_case(17'h04E20, PCRS_MULT_X0P1, PCRS_RATE_PER_SECOND, 10'h001, PCRS_QUADRATURE_FOUR_EDGE_MODE);
		// update time only grows from here on; shrinking it mid-window closes that window late
		rate_case(17'h0D903, PCRS_MULT_X0P01, PCRS_RATE_PER_SECOND, 10'h000, PCRS_SINGLE_EDGE_MODE);
		rate_case(17'h04E20, PCRS_MULT_X0P1, PCRS_RATE_PER_SECOND, 10'h002, PCRS_QUADRATURE_FOUR_EDGE_MODE);
	endtask

	task automatic results();
		$display("mismatches %0d, comparisons %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		rst_b_i = 1'b0;
		ccfg = '0;
		rcfg = '0;
		repeat (16) @(negedge clk_i);
		rst_b_i = 1'b1;
		check(count_o, 32'h0);
		check(rate_o, 32'h0);
		t_modes();
		t_mult();
		t_rate();
		results();
	end
	// whole run needs about 8000 cycles
	initial begin
		repeat (30000) @(posedge clk_i);
		n_mismatch++;
		results();
	end
endmodule // pcrs_scaler_bench
